// *** inc/wdtc_pkg.sv ***
package wdtc_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 4'h1;

  // Field positions
  localparam int IRQ_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int SEL_HI_BIT = 5;
  localparam int CHG_EN_BIT = 4;
  localparam int RST_EN_BIT = 3;
  localparam int SEL_LO_MSB = 2;
  localparam int WATCHDOG_RESET_FLAG_BIT = 3;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic WATCHDOG_RESET_FLAG_RESET = 1'b0;

  // Fuse level that means programmed
  localparam logic FUSE_PROGRAMMED = 1'b0;

  // Change-enable window, in system clock cycles
  localparam int CHG_WINDOW_CYC = 4;
  localparam int CHG_CNT_W = 3;
  localparam logic [CHG_CNT_W-1:0] CHG_LAST =
    CHG_CNT_W'(CHG_WINDOW_CYC - 1);

  // Time-out table: base count shifted left by the select value
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] BASE_TIMEOUT_CYC = 21'h000800;
  localparam logic [3:0] MAX_SEL = 4'h9;

  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic sel_hi;
    logic chg_en;
    logic rst_en;
    logic [2:0] sel_lo;
  } wdtc_ctrl_t;

  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_RESET = 2'b10,
    MODE_IRQ_RESET = 2'b11
  } wdtc_mode_t;

  // Reserved select codes are clamped to the longest period
  function automatic logic [CNT_W-1:0] timeout_limit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > MAX_SEL) ? MAX_SEL : sel;
    return BASE_TIMEOUT_CYC << s;
  endfunction

  function automatic wdtc_mode_t mode_decode(input logic fuse,
                                             input logic rst_en,
                                             input logic irq_en);
    if (fuse == FUSE_PROGRAMMED) begin
      return MODE_RESET;
    end
    return wdtc_mode_t'({rst_en, irq_en});
  endfunction

endpackage

// *** rtl/wdtc_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdtc_counter import wdtc_pkg::*; (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic tick_in,
  input wire logic [3:0] sel_in,
  output logic expired_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] cnt_inc;

  always_comb begin
    limit = timeout_limit(sel_in);
    cnt_inc = cnt_q + 21'h000001;
    // Greater-or-equal, so a shorter select fires on the next tick
    expired_out = run_in && tick_in && !restart_in && (cnt_inc >= limit);
    cnt_d = cnt_q;
    if (!run_in || restart_in) begin
      cnt_d = '0;
    end else if (expired_out) begin
      cnt_d = '0;
    end else if (tick_in) begin
      cnt_d = cnt_inc;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// *** rtl/wdtc_top.sv ***
// What this block does
// - Time-out in interrupt mode sets flag
// - Vector or written one clears flag
// - Interrupt needs flag, global and local enable
// - Combined mode vector clears enable and flag
// - In combined mode, unserviced flag at next time-out resets system
// - Enable pair selects stopped, irq, reset, both
// - Programmed fuse forces reset mode always
// - Change-enable self-clears after four clocks
// - Reset flag forces and locks reset enable
// - Select bits at 5 and 2..0
// - Period is 2048 shifted by select
// - Counter advances on oscillator ticks only
// - Restart instruction clears the counter
// - Watchdog reset sets flag; zero write clears
`timescale 1ns/1ps
`default_nettype none
module wdtc_top import wdtc_pkg::*; (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic osc_tick_in,
  input wire logic restart_in,
  input wire logic vector_taken_in,
  input wire logic global_irq_enable_in,
  input wire logic always_on_fuse_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic irq_out,
  output logic sys_reset_out,
  output logic running_out
);

  wdtc_ctrl_t ctrl_q;
  wdtc_ctrl_t ctrl_d;
  wdtc_ctrl_t wr_val;
  logic [CHG_CNT_W-1:0] chg_cnt_q;
  logic [CHG_CNT_W-1:0] chg_cnt_d;
  logic watchdog_reset_flag_q;
  logic watchdog_reset_flag_d;
  logic sys_reset_q;
  logic sys_reset_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic running_q;

  logic rst_en_eff;
  logic irq_en_eff;
  wdtc_mode_t mode;
  logic run;
  logic expired;
  logic wdog_reset;
  logic ctrl_wr;
  logic cause_wr;
  logic flag_set;
  logic [3:0] sel;

  // Effective view of the control bits, as software reads them
  always_comb begin
    // Reset flag overrides reset enable; the fuse forces it too
    rst_en_eff = ctrl_q.rst_en || watchdog_reset_flag_q ||
                 (always_on_fuse_in == FUSE_PROGRAMMED);
    irq_en_eff = ctrl_q.irq_en &&
                 (always_on_fuse_in != FUSE_PROGRAMMED);
    mode = mode_decode(always_on_fuse_in, rst_en_eff,
                       irq_en_eff);
    run = (mode != MODE_STOPPED);
    sel = {ctrl_q.sel_hi, ctrl_q.sel_lo};
  end

  wdtc_counter u_counter (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .run_in(run),
    .restart_in(restart_in || sys_reset_q),
    .tick_in(osc_tick_in),
    .sel_in(sel),
    .expired_out(expired)
  );

  // Decide what a time-out does in the current mode
  always_comb begin
    flag_set = 1'b0;
    wdog_reset = 1'b0;
    if (expired) begin
      unique case (mode)
        MODE_STOPPED: begin
          flag_set = 1'b0;
        end
        MODE_IRQ: begin
          flag_set = 1'b1;
        end
        MODE_RESET: begin
          wdog_reset = 1'b1;
        end
        MODE_IRQ_RESET: begin
          // A vector in this very cycle counts as serviced
          if (ctrl_q.irq_flag && !vector_taken_in) begin
            wdog_reset = 1'b1;
          end else begin
            flag_set = 1'b1;
          end
        end
      endcase
    end
  end

  // Control register next state
  always_comb begin
    ctrl_wr = wr_in && (addr_in == CTRL_OFFSET);
    wr_val = wdtc_ctrl_t'(wdata_in);
    ctrl_d = ctrl_q;
    chg_cnt_d = chg_cnt_q;

    if (ctrl_q.chg_en) begin
      if (chg_cnt_q == '0) begin
        ctrl_d.chg_en = 1'b0;
      end else begin
        chg_cnt_d = chg_cnt_q - 3'h1;
      end
    end

    if (ctrl_wr) begin
      ctrl_d.irq_en = wr_val.irq_en;
      if (wr_val.irq_flag) begin
        ctrl_d.irq_flag = 1'b0;
      end
      if (wr_val.chg_en && wr_val.rst_en) begin
        // Opens the timed window; select bits stay as they are
        ctrl_d.chg_en = 1'b1;
        ctrl_d.rst_en = 1'b1;
        chg_cnt_d = CHG_LAST;
      end else if (ctrl_q.chg_en && !wr_val.chg_en) begin
        // Second write of the sequence applies all settings at once
        ctrl_d.rst_en = wr_val.rst_en || watchdog_reset_flag_q;
        ctrl_d.sel_hi = wr_val.sel_hi;
        ctrl_d.sel_lo = wr_val.sel_lo;
        ctrl_d.chg_en = 1'b0;
        chg_cnt_d = '0;
      end else begin
        // Outside the window the reset enable can only be set
        ctrl_d.rst_en = ctrl_q.rst_en || wr_val.rst_en;
      end
    end

    if (vector_taken_in) begin
      ctrl_d.irq_flag = 1'b0;
      if (rst_en_eff) begin
        ctrl_d.irq_en = 1'b0;
      end
    end

    // Set wins over any clear in the same cycle
    if (flag_set) begin
      ctrl_d.irq_flag = 1'b1;
    end

    // A watchdog reset returns the control register to its reset value
    if (wdog_reset) begin
      ctrl_d = wdtc_ctrl_t'(CTRL_RESET);
      chg_cnt_d = '0;
    end
  end

  // Reset cause flag and reset pulse
  always_comb begin
    cause_wr = wr_in && (addr_in == CAUSE_OFFSET);
    watchdog_reset_flag_d = watchdog_reset_flag_q;
    if (cause_wr && !wdata_in[WATCHDOG_RESET_FLAG_BIT]) begin
      watchdog_reset_flag_d = 1'b0;
    end
    if (wdog_reset) begin
      watchdog_reset_flag_d = 1'b1;
    end
    sys_reset_d = wdog_reset;
  end

  // Read port: data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (rd_in) begin
      if (addr_in == CTRL_OFFSET) begin
        rdata_d[IRQ_FLAG_BIT] = ctrl_q.irq_flag;
        rdata_d[IRQ_EN_BIT] = irq_en_eff;
        rdata_d[SEL_HI_BIT] = ctrl_q.sel_hi;
        rdata_d[CHG_EN_BIT] = ctrl_q.chg_en;
        rdata_d[RST_EN_BIT] = rst_en_eff;
        rdata_d[SEL_LO_MSB:0] = ctrl_q.sel_lo;
      end else if (addr_in == CAUSE_OFFSET) begin
        rdata_d[WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_q;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ctrl_q <= wdtc_ctrl_t'(CTRL_RESET);
      chg_cnt_q <= '0;
      watchdog_reset_flag_q <= WATCHDOG_RESET_FLAG_RESET;
      sys_reset_q <= 1'b0;
      rdata_q <= '0;
      running_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      chg_cnt_q <= chg_cnt_d;
      watchdog_reset_flag_q <= watchdog_reset_flag_d;
      sys_reset_q <= sys_reset_d;
      rdata_q <= rdata_d;
      running_q <= run;
    end
  end

  // Global enable comes straight from the core, so the request is live
  assign irq_out = ctrl_q.irq_flag && irq_en_eff &&
                   global_irq_enable_in;
  assign sys_reset_out = sys_reset_q;
  assign rdata_out = rdata_q;
  assign running_out = running_q;

endmodule
`default_nettype wire

// *** testbench/wdtc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdtc_properties import wdtc_pkg::*; (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic osc_tick_in,
  input wire logic restart_in,
  input wire logic vector_taken_in,
  input wire logic global_irq_enable_in,
  input wire logic always_on_fuse_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic irq_out,
  input wire logic sys_reset_out,
  input wire logic running_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire rd_c = rd_in && addr_in == CTRL_OFFSET;
  wire open_w = wr_in && addr_in == CTRL_OFFSET &&
    wdata_in[CHG_EN_BIT] && wdata_in[RST_EN_BIT];
  irq_gate_a: assert property (
    irq_out |-> global_irq_enable_in && always_on_fuse_in)
    else $error("irq without enables");
  reset_tick_a: assert property (
    sys_reset_out |-> $past(osc_tick_in) ##1 !sys_reset_out)
    else $error("reset pulse not from a tick");
  reset_quiet_a: assert property (
    sys_reset_out |=> !irq_out)
    else $error("irq survives reset");
  chg_open_a: assert property (
    open_w ##1 rd_c |=> rdata_out[CHG_EN_BIT])
    else $error("window not open");
  chg_close_a: assert property (
    open_w ##1 !wr_in [*5] ##1 rd_c |=> !rdata_out[CHG_EN_BIT])
    else $error("window not closed");
  fuse_view_a: assert property (
    rd_c && always_on_fuse_in == FUSE_PROGRAMMED |=>
    rdata_out[RST_EN_BIT] && !rdata_out[IRQ_EN_BIT])
    else $error("fuse view wrong");
  vector_clear_a: assert property (
    vector_taken_in && !osc_tick_in |=> !irq_out)
    else $error("vector left irq");
  irq_running_a: assert property (
    irq_out && $past(irq_out) |-> running_out)
    else $error("irq while stopped");
endmodule
bind wdtc_top wdtc_properties chk (.*);
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import wdtc_pkg::*;;
  logic mclk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
  logic osc_tick_in = 0, restart_in = 0, vector_taken_in = 0;
  logic global_irq_enable_in = 1, always_on_fuse_in = 1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0, rdata_out, d, q;
  logic irq_out, sys_reset_out, running_out;
  int bad_count = 0, comparisons = 0, resets = 0, cyc = 0;
  // Row: address, fuse, write data, expected read back
  logic [20:0] rows [7] = '{{4'h0, 1'b1, 8'h40, 8'h40},
    {4'h0, 1'b1, 8'h00, 8'h00}, {4'h0, 1'b1, 8'h08, 8'h08},
    {4'h0, 1'b1, 8'h18, 8'h18}, {4'h0, 1'b1, 8'h27, 8'h27},
    {4'hf, 1'b1, 8'hff, 8'h00}, {4'h0, 1'b0, 8'h40, 8'h2f}};
  wdtc_top dut (.*);
  always #10 mclk_in = ~mclk_in;
  // Counted at the falling edge so the pulse is settled
  always @(negedge mclk_in) if (sys_reset_out === 1'b1) resets++;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    d = rdata_out;
    @(posedge mclk_in);
  endtask
  task automatic look();
    @(negedge mclk_in);
    q = {7'h00, irq_out};
    @(posedge mclk_in);
  endtask
  task automatic ticks(int n);
    osc_tick_in <= 1'b1;
    repeat (n) @(posedge mclk_in);
    osc_tick_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    look();
  endtask
  task automatic restart();
    restart_in <= 1'b1;
    @(posedge mclk_in);
    restart_in <= 1'b0;
  endtask
  task automatic vec();
    vector_taken_in <= 1'b1;
    @(posedge mclk_in);
    vector_taken_in <= 1'b0;
    look();
  endtask
  task automatic window(logic [7:0] v);
    wr(CTRL_OFFSET, 8'h18);
    @(posedge mclk_in);
    wr(CTRL_OFFSET, v);
    rd(CTRL_OFFSET);
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rd(CTRL_OFFSET);
    chk(d, CTRL_RESET);
    rd(CAUSE_OFFSET);
    chk(d, 8'h00);
    foreach (rows[i]) begin
      always_on_fuse_in <= rows[i][16];
      wr(rows[i][20:17], rows[i][15:8]);
      rd(rows[i][20:17]);
      chk(d, rows[i][7:0]);
    end
    $display("register rows done");
    always_on_fuse_in <= 1'b1;
    restart();
    window(8'h40);
    chk(d, 8'h40);
    ticks(2000);
    restart();
    ticks(2047);
    chk(q, 8'h00);
    ticks(1);
    chk(q, 8'h01);
    global_irq_enable_in <= 1'b0;
    look();
    chk(q, 8'h00);
    global_irq_enable_in <= 1'b1;
    vec();
    chk(q, 8'h00);
    ticks(2048);
    chk(q, 8'h01);
    wr(CTRL_OFFSET, 8'hc0);
    rd(CTRL_OFFSET);
    chk(d, 8'h40);
    $display("interrupt mode done");
    wr(CTRL_OFFSET, 8'h58);
    rd(CTRL_OFFSET);
    chk(d, 8'h58);
    repeat (3) @(posedge mclk_in);
    rd(CTRL_OFFSET);
    chk(d, 8'h48);
    restart();
    ticks(2048);
    chk(q, 8'h01);
    vec();
    rd(CTRL_OFFSET);
    chk(d, 8'h08);
    wr(CTRL_OFFSET, 8'h48);
    restart();
    ticks(2048);
    ticks(2047);
    chk(8'(resets), 8'h00);
    ticks(1);
    chk(8'(resets), 8'h01);
    rd(CAUSE_OFFSET);
    chk(d, 8'h08);
    window(8'h00);
    chk(d, 8'h08);
    wr(CAUSE_OFFSET, 8'h00);
    rd(CAUSE_OFFSET);
    chk(d, 8'h00);
    window(8'h00);
    chk(d, 8'h00);
    $display("combined mode done");
    always_on_fuse_in <= 1'b0;
    restart();
    ticks(2048);
    chk(8'(resets), 8'h02);
    @(negedge mclk_in);
    chk({7'h00, running_out}, 8'h01);
    $display("fuse mode done");
    // Power-on style reset in mid-run must clear the cause flag
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    always_on_fuse_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rd(CAUSE_OFFSET);
    chk(d, 8'h00);
    rd(CTRL_OFFSET);
    chk(d, CTRL_RESET);
    @(negedge mclk_in);
    chk({7'h00, running_out}, 8'h00);
    $display("reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
